// ===== acl_acc_load.sv
// accumulator next-value former for byte, word and long transfers
// assumes operand and current accumulator are stable during the commit cycle
`include "acl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module acl_acc_load
   import acl_pkg::*;
(
   input wire logic [31:0] acc, // current accumulator
   input wire logic [31:0] oper, // loaded operand
   input wire acl_width_e wid, // transfer width
   input wire acl_lh_e lh, // byte upper action
   input wire acl_ah_e ah, // high half action
   output logic [31:0] next_acc // accumulator after load
);
   logic [15:0] lo;
   // low half by width and byte upper action
   always_comb begin
      lo = acc[15:0];
      if (wid == ACL_BYTE) begin
         lo[7:0] = oper[7:0];
         if (lh == ACL_LH_ZERO) begin
            lo[15:8] = 8'h00;
         end else if (lh == ACL_LH_EXT) begin
            lo[15:8] = {8{oper[`ACL_BYTE_MSB]}};
         end
      end else begin
         lo = oper[15:0];
      end
   end
   // high half; long loads take the whole operand
   always_comb begin
      next_acc = {acc[31:16], lo};
      if (wid == ACL_LONG) begin
         next_acc = oper;
      end else begin
         case (ah)
            ACL_AH_COPY: next_acc[31:16] = acc[15:0];
            ACL_AH_ZERO: next_acc[31:16] = 16'h0000;
            ACL_AH_EXT: next_acc[31:16] = {16{lo[15]}};
            default: next_acc[31:16] = acc[31:16];
         endcase
      end
   end
endmodule // acl_acc_load
`default_nettype wire

// ===== acl_core.sv
// top of the accumulator load and flag datapath, with AXI4-Lite registers
// assumes one master, one write and one read at a time, synchronous reset
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`include "acl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module acl_core
   import acl_pkg::*;
#(
   parameter int MEM_WORDS = 16 // small operand memory for rmw
)(
   input wire logic clk_sys, // system clock
   input wire logic sys_rst, // sync reset, high
   input wire logic [11:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // response ready
   input wire logic [11:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read ready
   output logic busy, // instruction executing
   output logic stackFault // pointer beyond limits
);
   // ****************************************
   // state
   // ****************************************
   typedef enum logic [1:0] {ACL_IDLE, ACL_READ, ACL_WAIT, ACL_WRITE} acl_state_e;
   acl_state_e state;
   logic [31:0] ctrl, oper, acc, addr;
   logic [6:0] flags;
   logic [13:0] flagCtl;
   logic [15:0] user_stack_pointer, system_stack_pointer;
   logic [7:0] user_stack_bank, system_stack_bank;
   logic [15:0] stack_upper_limit, stack_lower_limit;
   logic [31:0] mem [MEM_WORDS];
   logic [4:0] cycLeft;
   logic [4:0] lastCycles;
   logic [31:0] rmwData;
   logic awHeld, wHeld;
   logic [11:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic [2:0] corr;
   logic [31:0] next_acc;
   logic [6:0] next_flags;
   // ****************************************
   // decoded fields
   // ****************************************
   acl_width_e wid;
   acl_lh_e acc_byte_upper_action;
   acl_ah_e accAhMode;
   logic read_modify_write_flag, ioForm;
   logic [15:0] acc_low_half, acc_high_half;
   logic [15:0] activeSp;
   logic [7:0] current_stack_bank;
   logic [23:0] physical_direct_address;
   logic [15:0] bankOffset;
   logic [7:0] bankNumber;
   logic [31:0] result;
   logic goWrite;
   assign wid = acl_width_e'(ctrl[`ACL_CTRL_WID_HI:`ACL_CTRL_WID_LO]);
   assign acc_byte_upper_action = acl_lh_e'(ctrl[`ACL_CTRL_LH_HI:`ACL_CTRL_LH_LO]);
   assign accAhMode = acl_ah_e'(ctrl[`ACL_CTRL_AH_HI:`ACL_CTRL_AH_LO]);
   assign read_modify_write_flag = ctrl[`ACL_CTRL_RMW];
   assign ioForm = ctrl[`ACL_CTRL_IO];
   assign acc_low_half = acc[15:0];
   assign acc_high_half = acc[31:16];
   // stack select flag chooses pointer and bank together
   assign activeSp = flags[`ACL_FLAG_S] ? system_stack_pointer : user_stack_pointer;
   assign current_stack_bank = flags[`ACL_FLAG_S] ? system_stack_bank : user_stack_bank;
   // short io form forces the top 16 address bits to zero
   assign physical_direct_address = ioForm ? {`ACL_IO_BANK_HI, addr[7:0]} : addr[23:0];
   assign bankOffset = physical_direct_address[15:0];
   assign bankNumber = physical_direct_address[23:16];
   // ****************************************
   // datapath helpers
   // ****************************************
   acl_cycle_corr u_corr (
      .loc(ctrl[`ACL_CTRL_LOC_HI:`ACL_CTRL_LOC_LO]),
      .wid(wid),
      .corr(corr)
   );
   acl_acc_load u_load (
      .acc(acc),
      .oper(read_modify_write_flag ? rmwData : oper),
      .wid(wid),
      .lh(acc_byte_upper_action),
      .ah(accAhMode),
      .next_acc(next_acc)
   );
   // rmw processing: increment, decrement, invert or pass
   function automatic logic [31:0] rmwOp(input logic [1:0] op, input logic [31:0] d);
      case (op)
         2'h0: rmwOp = d + 32'h1;
         2'h1: rmwOp = d - 32'h1;
         2'h2: rmwOp = ~d;
         default: rmwOp = d;
      endcase
   endfunction
   assign result = rmwOp(ctrl[`ACL_CTRL_RMWOP_HI:`ACL_CTRL_RMWOP_LO], rmwData);
   // per-flag update from a two-bit mode each
   function automatic logic flagNext(input logic [1:0] m, input logic cur, input logic res);
      case (acl_fmode_e'(m))
         ACL_F_RES: flagNext = res;
         ACL_F_KEEP: flagNext = cur;
         ACL_F_SET: flagNext = 1'b1;
         default: flagNext = 1'b0;
      endcase
   endfunction
   // Z and N come from the accumulator value being written, C from the rmw result
   always_comb begin
      logic [6:0] res;
      res = flags;
      res[`ACL_FLAG_Z] = (wid == ACL_LONG) ? (next_acc == 32'h0) :
         (wid == ACL_WORD) ? (next_acc[15:0] == 16'h0) : (next_acc[7:0] == 8'h0);
      res[`ACL_FLAG_N] = (wid == ACL_LONG) ? next_acc[31] :
         (wid == ACL_WORD) ? next_acc[15] : next_acc[7];
      res[`ACL_FLAG_C] = read_modify_write_flag && (result < rmwData);
      next_flags = flags;
      for (int i = 0; i < 7; i++) begin
         next_flags[i] = flagNext(flagCtl[2*i +: 2], flags[i], res[i]);
      end
   end
   // ****************************************
   // instruction sequencer
   // ****************************************
   assign goWrite = awHeld && wHeld && !s_axi_bvalid;
   // execution counts down base plus correction cycles
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state <= ACL_IDLE;
         cycLeft <= 5'h0;
         lastCycles <= 5'h0;
         busy <= 1'b0;
      end else begin
         case (state)
            ACL_IDLE: begin
               if (ctrl[`ACL_CTRL_GO]) begin
                  busy <= 1'b1;
                  lastCycles <= 5'(ctrl[`ACL_CTRL_BASE_HI:`ACL_CTRL_BASE_LO]) + 5'(corr);
                  cycLeft <= 5'(ctrl[`ACL_CTRL_BASE_HI:`ACL_CTRL_BASE_LO]) + 5'(corr);
                  state <= read_modify_write_flag ? ACL_READ : ACL_WAIT;
               end
            end
            ACL_READ: state <= ACL_WAIT;
            ACL_WAIT: begin
               if (cycLeft <= 5'h1) begin
                  state <= ACL_WRITE;
               end else begin
                  cycLeft <= cycLeft - 5'h1;
               end
            end
            default: begin
               state <= ACL_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end
   // memory window of 16 words starting at the mem offset
   function automatic logic memHit(input logic [11:0] a);
      memHit = (a >= `ACL_OFF_MEM) && (a <= `ACL_OFF_MEM + 12'h3c);
   endfunction
   // word index inside that window
   function automatic logic [3:0] memIdx(input logic [11:0] a);
      memIdx = 4'((a - `ACL_OFF_MEM) >> 2);
   endfunction
   // rmw operand capture and write-back to the same word
   always_ff @(posedge clk_sys) begin
      if (state == ACL_READ) begin
         rmwData <= mem[bankOffset[3:0]];
      end
      if (state == ACL_WRITE && read_modify_write_flag) begin
         mem[bankOffset[3:0]] <= result;
      end else if (goWrite && memHit(awAddr)) begin
         mem[memIdx(awAddr)] <= wData;
      end
   end
   // stack bound check against both limits
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         stackFault <= 1'b0;
      end else begin
         stackFault <= (activeSp > stack_upper_limit) || (activeSp < stack_lower_limit);
      end
   end
   // ****************************************
   // axi write channel
   // ****************************************
   // address and data latched independently, response after both
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 12'h0;
         wData <= 32'h0;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ACL_AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (goWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr > `ACL_OFF_MEM + 12'h3c) ? `ACL_AXI_SLVERR : `ACL_AXI_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;
   // byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         old[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
      end
      merge = old;
   endfunction
   // ****************************************
   // register file; commit beats software writes
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl <= 32'h0;
         oper <= 32'h0;
         acc <= 32'h0;
         addr <= 32'h0;
         flags <= `ACL_FLAGS_RST;
         flagCtl <= 14'h1555;
         user_stack_pointer <= 16'h0;
         system_stack_pointer <= 16'h0;
         user_stack_bank <= 8'h0;
         system_stack_bank <= 8'h0;
         stack_upper_limit <= 16'hffff;
         stack_lower_limit <= 16'h0;
      end else begin
         if (goWrite) begin
            if (awAddr == `ACL_OFF_CTRL) begin
               ctrl <= merge(ctrl, wData, wStrb);
            end else if (awAddr == `ACL_OFF_OPER) begin
               oper <= merge(oper, wData, wStrb);
            end else if (awAddr == `ACL_OFF_ACCLO) begin
               acc[15:0] <= 16'(merge({16'h0, acc[15:0]}, wData, wStrb));
            end else if (awAddr == `ACL_OFF_ACCHI) begin
               acc[31:16] <= 16'(merge({16'h0, acc[31:16]}, wData, wStrb));
            end else if (awAddr == `ACL_OFF_FLAGS) begin
               flags <= wData[6:0];
            end else if (awAddr == `ACL_OFF_FLAGCTL) begin
               flagCtl <= wData[13:0];
            end else if (awAddr == `ACL_OFF_USP) begin
               user_stack_pointer <= wData[15:0];
               user_stack_bank <= wData[23:16];
            end else if (awAddr == `ACL_OFF_SSP) begin
               system_stack_pointer <= wData[15:0];
               system_stack_bank <= wData[23:16];
            end else if (awAddr == `ACL_OFF_LIMITS) begin
               stack_lower_limit <= wData[15:0];
               stack_upper_limit <= wData[31:16];
            end else if (awAddr == `ACL_OFF_ADDR) begin
               addr <= wData;
            end
         end
         // go self-clears; one commit of acc and flags together
         if (state == ACL_IDLE && ctrl[`ACL_CTRL_GO]) begin
            ctrl[`ACL_CTRL_GO] <= 1'b0;
         end
         if (state == ACL_WRITE) begin
            acc <= next_acc;
            flags <= next_flags;
         end
      end
   end
   // ****************************************
   // axi read channel
   // ****************************************
   assign s_axi_arready = !s_axi_rvalid;
   // read decode; unmapped answers slverr with zero data
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `ACL_AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `ACL_AXI_OKAY;
         if (s_axi_araddr == `ACL_OFF_CTRL) begin
            s_axi_rdata <= ctrl;
         end else if (s_axi_araddr == `ACL_OFF_OPER) begin
            s_axi_rdata <= oper;
         end else if (s_axi_araddr == `ACL_OFF_ACCLO) begin
            s_axi_rdata <= {16'h0, acc_low_half};
         end else if (s_axi_araddr == `ACL_OFF_ACCHI) begin
            s_axi_rdata <= {16'h0, acc_high_half};
         end else if (s_axi_araddr == `ACL_OFF_FLAGS) begin
            s_axi_rdata <= {25'h0, flags};
         end else if (s_axi_araddr == `ACL_OFF_FLAGCTL) begin
            s_axi_rdata <= {18'h0, flagCtl};
         end else if (s_axi_araddr == `ACL_OFF_USP) begin
            s_axi_rdata <= {8'h0, user_stack_bank, user_stack_pointer};
         end else if (s_axi_araddr == `ACL_OFF_SSP) begin
            s_axi_rdata <= {8'h0, system_stack_bank, system_stack_pointer};
         end else if (s_axi_araddr == `ACL_OFF_BANKS) begin
            s_axi_rdata <= {8'h0, current_stack_bank, activeSp};
         end else if (s_axi_araddr == `ACL_OFF_LIMITS) begin
            s_axi_rdata <= {stack_upper_limit, stack_lower_limit};
         end else if (s_axi_araddr == `ACL_OFF_ADDR) begin
            s_axi_rdata <= {8'h0, bankNumber, bankOffset};
         end else if (s_axi_araddr == `ACL_OFF_STATUS) begin
            s_axi_rdata <= {22'h0, lastCycles, 3'h0, stackFault, busy};
         end else if (memHit(s_axi_araddr)) begin
            s_axi_rdata <= mem[memIdx(s_axi_araddr)];
         end else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ACL_AXI_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // acl_core
`default_nettype wire

// ===== acl_core_checker.sv
// checker on acl_core ports: bus handshakes, busy, reset
// assumes one clock clk_sys and a sync reset sys_rst
`include "acl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module acl_core_checker (
   input wire logic clk_sys, // clock
   input wire logic sys_rst, // sync reset
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic [1:0] s_axi_bresp, // b resp
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic [1:0] s_axi_rresp, // r resp
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready, // r ready
   input wire logic busy, // executing
   input wire logic stackFault // pointer out of bounds
);
   // ************
   // properties
   // ************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // answers stand until taken
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
   // one transfer per direction, so new requests wait
   AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
   AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == `ACL_AXI_SLVERR
      |-> s_axi_rdata == 32'h0) else $error("error read carries data");
   // longest case is base 15 plus 6 plus one read cycle
   AST_BUSY_BOUND: assert property ($rose(busy) |-> ##[1:30] !busy)
      else $error("instruction never completes");
   // reset clears outputs, so this one is not disabled by it
   AST_RST_IDLE: assert property (disable iff (1'b0) sys_rst |=> !busy && !s_axi_bvalid
      && !s_axi_rvalid) else $error("outputs active after reset");
   C_EXEC: cover property ($rose(busy));
   C_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == `ACL_AXI_SLVERR);
   C_FAULT: cover property ($rose(stackFault));
endmodule // acl_core_checker
bind acl_core acl_core_checker i_acl_core_checker (.*);
`default_nettype wire

// ===== acl_cycle_corr.sv
// cycle correction lookup by operand location and width
// assumes location code and width come from the control register
`timescale 1ns/1ps
`default_nettype none
module acl_cycle_corr
   import acl_pkg::*;
(
   input wire logic [2:0] loc, // operand location class
   input wire acl_width_e wid, // operand width
   output logic [2:0] corr // added cycles
);
   // location classes: reg, ram even, ram odd, ext even, ext odd, 8-bit bus
   always_comb begin
      corr = 3'h0;
      case (loc)
         3'h2: corr = (wid == ACL_BYTE) ? 3'h0 : (wid == ACL_WORD) ? 3'h1 : 3'h2;
         3'h3: corr = (wid == ACL_LONG) ? 3'h2 : 3'h1;
         3'h4, 3'h5: corr = (wid == ACL_BYTE) ? 3'h1 : (wid == ACL_WORD) ? 3'h3 : 3'h6;
         default: corr = 3'h0;
      endcase
   end
endmodule // acl_cycle_corr
`default_nettype wire

// ===== acl_map.svh
// register map and encodings for the accumulator load and flag datapath
// assumes an AXI4-Lite slave with 32-bit data, one register per aligned word
// Overview of operation
// - 32-bit accumulator; byte, word, long widths
// - zero-fill byte loads clear bits 15..8
// - extend byte loads sign-fill; untouched keeps bits
// - copy mode moves old low half up
// - zero mode clears high half; none keeps
// - extend mode fills high by sign
// - each flag: result, keep, set, clear
// - read-modify-write reads, processes, writes back same address
// - actual cycles equal base plus correction
// - short io form maps to 000000-0000ff
// - stack select picks user or system pointer, bank
// - 24-bit address splits offset and bank
// - stack upper and lower limit registers checked
`ifndef ACL_MAP_SVH
`define ACL_MAP_SVH
// ************
// register offsets
// ************
`define ACL_OFF_CTRL 12'h000
`define ACL_OFF_OPER 12'h004
`define ACL_OFF_ACCLO 12'h008
`define ACL_OFF_ACCHI 12'h00c
`define ACL_OFF_FLAGS 12'h010
`define ACL_OFF_FLAGCTL 12'h014
`define ACL_OFF_USP 12'h018
`define ACL_OFF_SSP 12'h01c
`define ACL_OFF_BANKS 12'h020
`define ACL_OFF_LIMITS 12'h024
`define ACL_OFF_ADDR 12'h028
`define ACL_OFF_STATUS 12'h02c
`define ACL_OFF_MEM 12'h030
// ************
// control field positions
// ************
`define ACL_CTRL_GO 0
`define ACL_CTRL_WID_LO 1
`define ACL_CTRL_WID_HI 2
`define ACL_CTRL_LH_LO 3
`define ACL_CTRL_LH_HI 4
`define ACL_CTRL_AH_LO 5
`define ACL_CTRL_AH_HI 6
`define ACL_CTRL_RMW 7
`define ACL_CTRL_IO 8
`define ACL_CTRL_LOC_LO 9
`define ACL_CTRL_LOC_HI 11
`define ACL_CTRL_BASE_LO 12
`define ACL_CTRL_BASE_HI 15
`define ACL_CTRL_RMWOP_LO 16
`define ACL_CTRL_RMWOP_HI 17
// ************
// flag positions and reset values
// ************
`define ACL_FLAG_C 0
`define ACL_FLAG_V 1
`define ACL_FLAG_Z 2
`define ACL_FLAG_N 3
`define ACL_FLAG_T 4
`define ACL_FLAG_S 5
`define ACL_FLAG_I 6
`define ACL_FLAGS_RST 7'h20
`define ACL_IO_BANK_HI 16'h0000
`define ACL_BYTE_MSB 7
`define ACL_AXI_OKAY 2'h0
`define ACL_AXI_SLVERR 2'h2
`endif

// ===== acl_pkg.sv
// types shared by the accumulator datapath files
// assumes acl_map.svh supplies the numeric constants
package acl_pkg;
   typedef enum logic [1:0] {ACL_BYTE, ACL_WORD, ACL_LONG, ACL_WRSV} acl_width_e;
   typedef enum logic [1:0] {ACL_LH_NONE, ACL_LH_ZERO, ACL_LH_EXT, ACL_LH_RSV} acl_lh_e;
   typedef enum logic [1:0] {ACL_AH_NONE, ACL_AH_COPY, ACL_AH_ZERO, ACL_AH_EXT} acl_ah_e;
   typedef enum logic [1:0] {ACL_F_RES, ACL_F_KEEP, ACL_F_SET, ACL_F_CLR} acl_fmode_e;
endpackage

// ===== test_acl_core.sv
// self-checking bench for acl_core: registers, loads, flags, cycles, rmw
// assumes the checker binds itself; map header on include path
`include "acl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_acl_core
   import acl_pkg::*;
;
   typedef struct packed {
      acl_width_e w;
      acl_lh_e l;
      acl_ah_e h;
      logic [31:0] op;
      logic [15:0] lo;
      logic [15:0] hi;
   } acl_tcase_s;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic busy, stackFault;
   int fails = 0, compares = 0, i;
   acl_tcase_s tc [7];
   logic [2:0] cl [5] = '{3'h3, 3'h4, 3'h5, 3'h2, 3'h2};
   logic [3:0] cb [5] = '{4'h2, 4'h3, 4'h1, 4'h4, 4'h2};
   logic [1:0] cw [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
   logic [4:0] ce [5] = '{5'h3, 5'h6, 5'h7, 5'h5, 5'h4};
   acl_core i_acl_core (.*);
   // 125 MHz clock
   always #4 clk_sys = ~clk_sys;
   // ************
   // bus tasks
   // ************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
      logic ta, tw, tb;
      logic [1:0] r;
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      tb = 1'b0;
      for (n = 0; n < 50 && !tb; n++) begin
         @(negedge clk_sys);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid === 1'b1;
         r = s_axi_bresp;
         @(posedge clk_sys);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
      end
      chk({29'h0, !tb, r}, {30'h0, er});
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v, input logic [1:0] er = 2'h0);
      logic ta, tr;
      logic [1:0] r;
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      tr = 1'b0;
      for (n = 0; n < 50 && !tr; n++) begin
         @(negedge clk_sys);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid === 1'b1;
         v = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk_sys);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) s_axi_rready <= 1'b0;
      end
      chk({29'h0, !tr, r}, {30'h0, er});
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      logic [31:0] v;
      rd(a, v, er);
      chk(v, e);
   endtask
   function automatic logic [31:0] mk(input acl_width_e w, acl_lh_e l, acl_ah_e h,
      logic [2:0] loc, logic [3:0] b);
      return {16'h0, b, loc, 2'b00, h, l, w, 1'b1};
   endfunction
   // start an instruction and wait, bounded, until busy falls
   task automatic ex(input logic [31:0] c);
      int n;
      wr(`ACL_OFF_CTRL, c);
      for (n = 0; n < 60 && (n < 3 || busy !== 1'b0); n++) @(negedge clk_sys);
      chk({31'h0, busy}, 32'h0);
   endtask
   task automatic tally_and_finish;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ************
   // tests
   // ************
   // watchdog: whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      tc = '{'{ACL_BYTE, ACL_LH_NONE, ACL_AH_NONE, 32'hf5, 16'h12f5, 16'habcd},
         '{ACL_BYTE, ACL_LH_ZERO, ACL_AH_COPY, 32'hf5, 16'h00f5, 16'h1234},
         '{ACL_BYTE, ACL_LH_EXT, ACL_AH_ZERO, 32'hf5, 16'hfff5, 16'h0000},
         '{ACL_BYTE, ACL_LH_EXT, ACL_AH_EXT, 32'hf5, 16'hfff5, 16'hffff},
         '{ACL_BYTE, ACL_LH_ZERO, ACL_AH_EXT, 32'hf5, 16'h00f5, 16'h0000},
         '{ACL_WORD, ACL_LH_NONE, ACL_AH_EXT, 32'h8001, 16'h8001, 16'hffff},
         '{ACL_LONG, ACL_LH_NONE, ACL_AH_NONE, 32'h89abcdef, 16'hcdef, 16'h89ab}};
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rc(`ACL_OFF_ACCHI, 32'h0);
      rc(`ACL_OFF_FLAGS, 32'h20);
      rc(`ACL_OFF_FLAGCTL, 32'h1555);
      rc(`ACL_OFF_LIMITS, 32'hffff0000);
      rc(12'h0f0, 32'h0, `ACL_AXI_SLVERR);
      wr(12'h0f0, 32'h1, `ACL_AXI_SLVERR);
      $display("test reset done");
      wr(`ACL_OFF_USP, 32'h00110200);
      wr(`ACL_OFF_SSP, 32'h0022ff00);
      wr(`ACL_OFF_BANKS, 32'h0);
      rc(`ACL_OFF_BANKS, 32'h0022ff00);
      wr(`ACL_OFF_LIMITS, 32'h10000100);
      repeat (2) @(negedge clk_sys);
      chk({31'h0, stackFault}, 32'h1);
      $display("test stack done");
      for (i = 0; i < 7; i++) begin
         wr(`ACL_OFF_ACCLO, 32'h1234);
         wr(`ACL_OFF_ACCHI, 32'habcd);
         wr(`ACL_OFF_OPER, tc[i].op);
         ex(mk(tc[i].w, tc[i].l, tc[i].h, 3'h0, 4'h1));
         rc(`ACL_OFF_ACCLO, {16'h0, tc[i].lo});
         rc(`ACL_OFF_ACCHI, {16'h0, tc[i].hi});
      end
      rc(`ACL_OFF_FLAGS, 32'h20);
      $display("test loads done");
      for (i = 0; i < 5; i++) begin
         ex(mk(acl_width_e'(cw[i]), ACL_LH_NONE, ACL_AH_NONE, cl[i], cb[i]));
         rd(`ACL_OFF_STATUS, d);
         chk({27'h0, d[9:5]}, {27'h0, ce[i]});
      end
      $display("test cycles done");
      // set T and I, clear S, N and Z from the byte result
      wr(`ACL_OFF_FLAGCTL, 32'h2e05);
      wr(`ACL_OFF_OPER, 32'hf5);
      ex(mk(ACL_BYTE, ACL_LH_ZERO, ACL_AH_NONE, 3'h0, 4'h1));
      rc(`ACL_OFF_FLAGS, 32'h58);
      wr(`ACL_OFF_OPER, 32'h100);
      ex(mk(ACL_BYTE, ACL_LH_ZERO, ACL_AH_NONE, 3'h0, 4'h1));
      rc(`ACL_OFF_FLAGS, 32'h54);
      rc(`ACL_OFF_BANKS, 32'h00110200);
      chk({31'h0, stackFault}, 32'h0);
      $display("test flags done");
      wr(`ACL_OFF_ADDR, 32'h005a1234);
      rc(`ACL_OFF_ADDR, 32'h005a1234);
      wr(`ACL_OFF_CTRL, 32'h100);
      wr(`ACL_OFF_ADDR, 32'h005a12c7);
      rc(`ACL_OFF_ADDR, 32'h000000c7);
      wr(`ACL_OFF_CTRL, 32'h0);
      $display("test address done");
      wr(`ACL_OFF_ADDR, 32'h2);
      wr(12'h038, 32'h7f);
      ex(mk(ACL_LONG, ACL_LH_NONE, ACL_AH_NONE, 3'h0, 4'h1) | 32'h80);
      rc(12'h038, 32'h80);
      rc(`ACL_OFF_ACCLO, 32'h7f);
      rc(`ACL_OFF_ACCHI, 32'h0);
      $display("test rmw done");
      tally_and_finish();
   end
endmodule // test_acl_core
`default_nettype wire
